// ### rtl/bcp_regs.svh
// Purpose: constants for the block code protection unit
// Assumes: 22-bit table address space, byte wide data
// Notes:   Contract list below
`ifndef BCP_REGS_SVH
`define BCP_REGS_SVH

// ==========================================================================
// memory map
`define BCP_BOOT_END      22'h0007FF
`define BCP_BLK0_START    16'h0800
`define BCP_STEP_SMALL    16'h2000
`define BCP_STEP_BIG      16'h4000
`define BCP_SIZE_UNIT     16384
`define BCP_FULL_END      16'hFFFF
`define BCP_ID_LO_ADDR    22'h3FFFFE
`define BCP_ID_HI_ADDR    22'h3FFFFF

// ==========================================================================
// protection bytes and fields
`define BCP_READ_GUARD_LOW        22'h300008
`define BCP_BOOT_READ_GUARD       22'h300009
`define BCP_WRITE_GUARD_LOW       22'h30000A
`define BCP_BOOT_CFG_WRITE_GUARD  22'h30000B
`define BCP_TREAD_GUARD_LOW       22'h30000C
`define BCP_BOOT_TREAD_GUARD      22'h30000D
`define BCP_BLK_MSB       3
`define BCP_BOOT_BIT      6
`define BCP_CFGW_BIT      5

// ==========================================================================
// block codes and reset values
`define BCP_BLK_BOOT      3'h4
`define BCP_BLK_NONE      3'h7
`define BCP_ERASED        8'hFF
`define BCP_GUARD_ERASED  16'hFFFF

`endif

// ### rtl/bcp_pkg.sv
// Purpose: types of the block code protection unit
// Assumes: constants come from bcp_regs.svh
// Notes:   lock vectors index blocks 0..3, index 4 is boot
package bcp_pkg;

  typedef enum logic {BCP_IDLE, BCP_ERASE} bcp_mode_t;

  typedef struct packed {
    logic [4:0] readLock;
    logic [4:0] writeLock;
    logic [4:0] tableReadLock;
    logic       configWriteLock;
  } bcp_guard_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        erase;
    logic [21:0] addr;
    logic [21:0] pc;
    logic [7:0]  wdata;
  } bcp_core_req_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        chipErase;
    logic        blockErase;
    logic [2:0]  blk;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } bcp_prog_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bcp_rsp_t;

  typedef struct packed {
    bcp_mode_t  mode;
    logic [15:0] eraseAddr;
    logic [15:0] eraseEnd;
    bcp_guard_t guard;
    bcp_rsp_t   coreRsp;
    bcp_rsp_t   progRsp;
    logic       busy;
  } bcp_state_t;

endpackage

// ### rtl/bcp_block_decode.sv
// Purpose: map a table address to its protection block
// Assumes: SIZE_SEL 0..3 selects 16/32/48/64 KB
// Notes:   outside implemented memory gives the none code
`timescale 1ns/100ps
`include "bcp_regs.svh"

module bcp_block_decode
  import bcp_pkg::*;
#(
  parameter logic [1:0] SIZE_SEL = 2'h3
)
(
  input  wire logic [21:0] addr,
  output      logic [2:0]  blk
);

  localparam logic [21:0] IMPL_END = 22'((int'(SIZE_SEL) + 1) * `BCP_SIZE_UNIT - 1);

  always_comb
  begin
    if (addr > IMPL_END)
      blk = `BCP_BLK_NONE;
    else if (addr <= `BCP_BOOT_END)
      blk = `BCP_BLK_BOOT;
    else if (SIZE_SEL[1])
      blk = {1'b0, addr[15:14]};
    else
      blk = {1'b0, addr[14:13]};
  end

endmodule

// ### rtl/bcp_top.sv
// Purpose: block code protection for program memory table access
// Assumes: core and programmer requests are one-cycle pulses
// Notes:   programmer wins when both ask in the same cycle
`timescale 1ns/100ps
`include "bcp_regs.svh"

module bcp_top
  import bcp_pkg::*;
#(
  parameter logic [1:0] SIZE_SEL = 2'h3,
  parameter logic [7:0] ID_LO    = 8'h5A,   // arbitrary value
  parameter logic [7:0] ID_HI    = 8'hA5    // arbitrary value
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire bcp_core_req_t coreIn,
  input  wire bcp_prog_req_t progIn,
  output      bcp_rsp_t      coreOut,
  output      bcp_rsp_t      progOut,
  output      logic          progBusy
);

  // ==========================================================================
  // state and storage
  localparam bcp_state_t ST_RST = '{mode: BCP_IDLE, eraseAddr: 16'h0000,
                                    eraseEnd: 16'h0000, guard: `BCP_GUARD_ERASED,
                                    coreRsp: 9'h000, progRsp: 9'h000, busy: 1'b0};

  bcp_state_t  st_q;
  bcp_state_t  st_d;
  logic [7:0]  mem [0:65535];
  logic        memWe;
  logic [15:0] memWa;
  logic [7:0]  memWd;

  logic [2:0]  coreTgt;
  logic [2:0]  corePcBlk;
  logic [2:0]  progTgt;
  logic        coreTake;
  logic        progTake;
  logic        coreInMem;
  logic        progInMem;
  logic        coreTrOpen;
  logic        coreWlock;
  logic        coreRdOpen;
  logic        progRdOpen;
  logic        coreReadOk;
  logic        eraseStart;
  logic [7:0]  coreMemByte;
  logic [7:0]  progMemByte;
  logic [15:0] stepSz;
  logic [15:0] blkBase;
  logic [15:0] guardBits;

  // ==========================================================================
  // address decode
  bcp_block_decode #(.SIZE_SEL(SIZE_SEL)) uCoreTgt
  (
    .addr (coreIn.addr),
    .blk  (coreTgt)
  );

  bcp_block_decode #(.SIZE_SEL(SIZE_SEL)) uCorePc
  (
    .addr (coreIn.pc),
    .blk  (corePcBlk)
  );

  bcp_block_decode #(.SIZE_SEL(SIZE_SEL)) uProgTgt
  (
    .addr (progIn.addr),
    .blk  (progTgt)
  );

  assign coreInMem   = coreTgt != `BCP_BLK_NONE;
  assign progInMem   = progTgt != `BCP_BLK_NONE;
  assign coreTrOpen  = coreInMem ? st_q.guard.tableReadLock[coreTgt] : 1'b0;
  assign coreWlock   = coreInMem ? st_q.guard.writeLock[coreTgt] : 1'b0;
  assign coreRdOpen  = coreInMem ? st_q.guard.readLock[coreTgt] : 1'b0;
  assign progRdOpen  = progInMem ? st_q.guard.readLock[progTgt] : 1'b0;
  assign coreReadOk  = coreTrOpen || (corePcBlk == coreTgt);
  assign coreMemByte = mem[coreIn.addr[15:0]];
  assign progMemByte = mem[progIn.addr[15:0]];
  assign progTake    = progIn.req && (st_q.mode == BCP_IDLE);
  // programmer has priority; a colliding core request gets no answer
  assign coreTake    = coreIn.req && !progIn.req && (st_q.mode == BCP_IDLE);
  assign eraseStart  = progTake && (progIn.chipErase ||
                       (progIn.blockErase && progIn.blk <= `BCP_BLK_BOOT));
  assign stepSz      = SIZE_SEL[1] ? `BCP_STEP_BIG : `BCP_STEP_SMALL;
  assign blkBase     = 16'(progIn.blk[1:0] * stepSz);
  assign guardBits   = st_q.guard;

  // ==========================================================================
  // configuration bytes, identification and protection updates
  function automatic logic [7:0] specialRead(input logic [21:0] a, input bcp_guard_t g);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `BCP_READ_GUARD_LOW:       r[`BCP_BLK_MSB:0] = g.readLock[3:0];
      `BCP_BOOT_READ_GUARD:      r[`BCP_BOOT_BIT] = g.readLock[4];
      `BCP_WRITE_GUARD_LOW:      r[`BCP_BLK_MSB:0] = g.writeLock[3:0];
      `BCP_BOOT_CFG_WRITE_GUARD:
      begin
        r[`BCP_BOOT_BIT] = g.writeLock[4];
        r[`BCP_CFGW_BIT] = g.configWriteLock;
      end
      `BCP_TREAD_GUARD_LOW:      r[`BCP_BLK_MSB:0] = g.tableReadLock[3:0];
      `BCP_BOOT_TREAD_GUARD:     r[`BCP_BOOT_BIT] = g.tableReadLock[4];
      `BCP_ID_LO_ADDR:           r = ID_LO;
      `BCP_ID_HI_ADDR:           r = ID_HI;
      default:                   r = 8'h00;
    endcase
    return r;
  endfunction

  // writes can only clear bits, so a locked block stays locked until erased or reset
  function automatic bcp_guard_t guardWrite(input logic [21:0] a, input logic [7:0] d,
                                            input bcp_guard_t g, input logic prog);
    bcp_guard_t n;
    n = g;
    case (a)
      `BCP_READ_GUARD_LOW:  n.readLock[3:0] = g.readLock[3:0] & d[`BCP_BLK_MSB:0];
      `BCP_BOOT_READ_GUARD: n.readLock[4] = g.readLock[4] & d[`BCP_BOOT_BIT];
      `BCP_WRITE_GUARD_LOW: n.writeLock[3:0] = g.writeLock[3:0] & d[`BCP_BLK_MSB:0];
      `BCP_BOOT_CFG_WRITE_GUARD:
      begin
        n.writeLock[4] = g.writeLock[4] & d[`BCP_BOOT_BIT];
        if (prog)
          n.configWriteLock = g.configWriteLock & d[`BCP_CFGW_BIT];
      end
      `BCP_TREAD_GUARD_LOW:  n.tableReadLock[3:0] = g.tableReadLock[3:0] & d[`BCP_BLK_MSB:0];
      `BCP_BOOT_TREAD_GUARD: n.tableReadLock[4] = g.tableReadLock[4] & d[`BCP_BOOT_BIT];
      default:               n = g;
    endcase
    return n;
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    st_d         = st_q;
    st_d.coreRsp = 9'h000;
    st_d.progRsp = 9'h000;
    memWe        = 1'b0;
    memWa        = 16'h0000;
    memWd        = 8'h00;
    case (st_q.mode)
      BCP_IDLE:
      begin
        if (progTake)
        begin
          if (progIn.chipErase)
          begin
            st_d.guard     = `BCP_GUARD_ERASED;
            st_d.eraseAddr = 16'h0000;
            st_d.eraseEnd  = `BCP_FULL_END;
            st_d.mode      = BCP_ERASE;
          end
          else if (progIn.blockErase)
          begin
            if (progIn.blk == `BCP_BLK_BOOT)
            begin
              st_d.eraseAddr = 16'h0000;
              st_d.eraseEnd  = 16'(`BCP_BOOT_END);
            end
            else
            begin
              st_d.eraseAddr = (progIn.blk[1:0] == 2'h0) ? `BCP_BLK0_START : blkBase;
              st_d.eraseEnd  = 16'(17'(blkBase) + 17'(stepSz) - 17'h00001);
            end
            if (progIn.blk <= `BCP_BLK_BOOT)
            begin
              st_d.guard.readLock[progIn.blk]      = 1'b1;
              st_d.guard.writeLock[progIn.blk]     = 1'b1;
              st_d.guard.tableReadLock[progIn.blk] = 1'b1;
              st_d.mode                            = BCP_ERASE;
            end
            else
              st_d.progRsp.valid = 1'b1;
          end
          else if (progIn.write)
          begin
            st_d.progRsp.valid = 1'b1;
            if (progInMem)
            begin
              memWe = progRdOpen;
              memWa = progIn.addr[15:0];
              memWd = progIn.wdata;
            end
            else
              st_d.guard = guardWrite(progIn.addr, progIn.wdata, st_q.guard, 1'b1);
          end
          else
          begin
            st_d.progRsp.valid = 1'b1;
            if (progInMem)
              st_d.progRsp.data = progRdOpen ? progMemByte : 8'h00;
            else
              st_d.progRsp.data = specialRead(progIn.addr, st_q.guard);
          end
        end
        else if (coreTake)
        begin
          st_d.coreRsp.valid = 1'b1;
          if (coreIn.write || coreIn.erase)
          begin
            // core erase reaches one byte only; whole erases are programmer-only
            if (coreInMem)
            begin
              memWe = coreWlock;
              memWa = coreIn.addr[15:0];
              memWd = coreIn.erase ? `BCP_ERASED : coreIn.wdata;
            end
            else if (!coreIn.erase && st_q.guard.configWriteLock)
              st_d.guard = guardWrite(coreIn.addr, coreIn.wdata, st_q.guard, 1'b0);
          end
          else if (coreInMem)
            st_d.coreRsp.data = coreReadOk ? coreMemByte : 8'h00;
          else
            st_d.coreRsp.data = specialRead(coreIn.addr, st_q.guard);
        end
      end
      BCP_ERASE:
      begin
        memWe = 1'b1;
        memWa = st_q.eraseAddr;
        memWd = `BCP_ERASED;
        if (st_q.eraseAddr == st_q.eraseEnd)
        begin
          st_d.mode          = BCP_IDLE;
          st_d.progRsp.valid = 1'b1;
        end
        else
          st_d.eraseAddr = st_q.eraseAddr + 16'h0001;
      end
      default: st_d.mode = BCP_IDLE;
    endcase
    st_d.busy = st_d.mode == BCP_ERASE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  // flash array keeps its content over reset
  always_ff @(posedge clk)
  begin
    if (memWe)
      mem[memWa] <= memWd;
  end

  assign coreOut  = st_q.coreRsp;
  assign progOut  = st_q.progRsp;
  assign progBusy = st_q.busy;

  // ==========================================================================
  // checks
  a_deny_reads_zero: assert property (@(posedge clk) disable iff (rst)
    coreTake && !coreIn.write && !coreIn.erase && coreInMem && !coreTrOpen &&
    corePcBlk != coreTgt |=> coreOut.valid && coreOut.data == 8'h00)
    else $error("denied table read did not return zero");

  a_own_block_read: assert property (@(posedge clk) disable iff (rst)
    coreTake && !coreIn.write && !coreIn.erase && coreInMem && corePcBlk == coreTgt
    |=> coreOut.valid && coreOut.data == $past(coreMemByte))
    else $error("own block read did not return memory");

  a_open_read_data: assert property (@(posedge clk) disable iff (rst)
    coreTake && !coreIn.write && !coreIn.erase && coreTrOpen
    |=> coreOut.data == $past(coreMemByte))
    else $error("open block read did not return memory");

  a_core_ignores_lock: assert property (@(posedge clk) disable iff (rst)
    coreTake && !coreIn.write && !coreIn.erase && coreInMem && !coreRdOpen && coreReadOk
    |=> coreOut.data == $past(coreMemByte))
    else $error("read lock altered a core read");

  a_wlock_no_write: assert property (@(posedge clk) disable iff (rst)
    coreTake && (coreIn.write || coreIn.erase) && coreInMem && !coreWlock |-> !memWe)
    else $error("write to write-locked block went through");

  a_guard_no_set: assert property (@(posedge clk) disable iff (rst)
    !eraseStart |=> (guardBits & ~$past(guardBits)) == 16'h0000)
    else $error("lock bit rose without an erase");

  a_erase_restores: assert property (@(posedge clk) disable iff (rst)
    progTake && progIn.chipErase |=> guardBits == 16'hFFFF ##1 progBusy)
    else $error("chip erase did not restore lock bits");

  a_cfgw_core_ro: assert property (@(posedge clk) disable iff (rst)
    coreTake |=> $stable(st_q.guard.configWriteLock))
    else $error("core changed config write lock");

  a_cfg_write_gate: assert property (@(posedge clk) disable iff (rst)
    coreTake && coreIn.write && !coreInMem && !st_q.guard.configWriteLock
    |=> $stable(guardBits))
    else $error("config write went through while locked");

  a_prog_read_lock: assert property (@(posedge clk) disable iff (rst)
    progTake && !progIn.write && !progIn.chipErase && !progIn.blockErase &&
    progInMem && !progRdOpen |=> progOut.valid && progOut.data == 8'h00)
    else $error("programmer read a code-protected block");

  a_id_read: assert property (@(posedge clk) disable iff (rst)
    coreTake && !coreIn.write && !coreIn.erase && coreIn.addr == `BCP_ID_LO_ADDR
    |=> coreOut.data == ID_LO)
    else $error("identification read wrong");

endmodule

// ### bench/bcp_host_model.sv
// Purpose: core and programmer side that issues table requests
// Assumes: tasks are entered 1 ns after a rising edge
// Notes:   released address, pc, block and data lines carry inverted values; req and control bits go low
`timescale 1ns/100ps
module bcp_host_model
  import bcp_pkg::*;
(
  input  wire logic          clk,
  output      bcp_core_req_t coreIn,
  output      bcp_prog_req_t progIn
);
  initial
  begin
    coreIn = '0;
    progIn = '0;
  end

  // ==========================================================================
  // requests
  // one-cycle pulse; caller samples the answer on return
  // an idle edge first, so a release and the next request never share a step
  task automatic core_req(input logic wr, input logic er, input logic [21:0] a,
                          input logic [21:0] p, input logic [7:0] d);
    @(posedge clk);
    #1 coreIn = '{1'b1, wr, er, a, p, d};
    @(posedge clk);
    #1 coreIn = '{1'b0, 1'b0, 1'b0, ~a, ~p, ~d};
  endtask

  // chip and block erases start only from this side, the core can erase single bytes only
  task automatic prog_req(input logic wr, input logic ce, input logic be,
                          input logic [2:0] b, input logic [21:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 progIn = '{1'b1, wr, ce, be, b, a, d};
    @(posedge clk);
    #1 progIn = '{1'b0, 1'b0, 1'b0, 1'b0, ~b, ~a, ~d};
  endtask
endmodule

// ### bench/testbench.sv
// Purpose: self-checking bench for the block code protection unit
// Assumes: 64 KB map, memory erased before any data read
// Notes:   reference model keeps locks and bytes in integers and arrays
`timescale 1ns/100ps
module testbench;
  import bcp_pkg::*;
  localparam logic [7:0] ID_LO_V = 8'h3C; // arbitrary value
  localparam logic [7:0] ID_HI_V = 8'hC3; // arbitrary value
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  bcp_core_req_t coreIn;
  bcp_prog_req_t progIn;
  bcp_rsp_t      coreOut;
  bcp_rsp_t      progOut;
  logic          progBusy;
  int            err_count = 0;
  int            cmp_count = 0;
  logic [7:0]    mem [int];
  logic [4:0]    rl = 5'h1F;
  logic [4:0]    wl = 5'h1F;
  logic [4:0]    trl = 5'h1F;
  logic          cfgw = 1'b1;
  logic [21:0]   edges [7] = '{22'h0007FF, 22'h000800, 22'h003FFF, 22'h004000,
                              22'h00BFFF, 22'h00C000, 22'h00FFFF};

  always #25 clk = ~clk;

  bcp_host_model host (.clk(clk), .coreIn(coreIn), .progIn(progIn));
  // full map: every block exists, so no lock bit has to be kept set
  bcp_top #(.SIZE_SEL(2'h3), .ID_LO(ID_LO_V), .ID_HI(ID_HI_V)) dut
    (.clk(clk), .rst(rst), .coreIn(coreIn), .progIn(progIn),
     .coreOut(coreOut), .progOut(progOut), .progBusy(progBusy));

  // ==========================================================================
  // reference model
  function automatic int blk_of(logic [21:0] a);
    if (a < 22'h000800) return 4;
    if (a < 22'h004000) return 0;
    if (a < 22'h010000) return int'(a >> 14);
    return 7;
  endfunction

  function automatic logic [7:0] mem_rd(logic [21:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction

  function automatic logic [7:0] cfg_rd(logic [21:0] a);
    case (a)
      22'h300008: return {4'h0, rl[3:0]};
      22'h300009: return {1'b0, rl[4], 6'h00};
      22'h30000A: return {4'h0, wl[3:0]};
      22'h30000B: return {1'b0, wl[4], cfgw, 5'h00};
      22'h30000C: return {4'h0, trl[3:0]};
      22'h30000D: return {1'b0, trl[4], 6'h00};
      22'h3FFFFE: return ID_LO_V;
      22'h3FFFFF: return ID_HI_V;
      default:    return 8'h00;
    endcase
  endfunction

  // lock bits only ever clear through writes
  function automatic void cfg_wr(logic [21:0] a, logic [7:0] d, logic prog);
    case (a)
      22'h300008: rl[3:0] &= d[3:0];
      22'h300009: rl[4] &= d[6];
      22'h30000A: wl[3:0] &= d[3:0];
      22'h30000B:
      begin
        wl[4] &= d[6];
        cfgw &= d[5] | ~prog;
      end
      22'h30000C: trl[3:0] &= d[3:0];
      22'h30000D: trl[4] &= d[6];
      default: ;
    endcase
  endfunction

  // ==========================================================================
  // checking and transfers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic core_op(input logic wr, input logic er, input logic [21:0] a,
                         input logic [21:0] p, input logic [7:0] d);
    int b;
    logic [7:0] exp;
    b = blk_of(a);
    exp = 8'h00;
    if ((wr || er) && b != 7 && wl[b])
      mem[int'(a)] = er ? 8'hFF : d;
    else if (wr && !er && b == 7 && cfgw)
      cfg_wr(a, d, 1'b0);
    else if (!(wr || er) && b != 7)
      exp = (trl[b] || blk_of(p) == b) ? mem_rd(a) : 8'h00;
    else if (!(wr || er))
      exp = cfg_rd(a);
    host.core_req(wr, er, a, p, d);
    check({coreOut.valid, (wr || er) ? 8'h00 : coreOut.data}, {1'b1, exp});
  endtask

  task automatic prog_op(input logic wr, input logic [21:0] a, input logic [7:0] d);
    int b;
    logic [7:0] exp;
    b = blk_of(a);
    exp = 8'h00;
    if (wr)
      cfg_wr(a, d, 1'b1);
    else
      exp = (b == 7) ? cfg_rd(a) : (rl[b] ? mem_rd(a) : 8'h00);
    host.prog_req(wr, 1'b0, 1'b0, 3'h0, a, d);
    check({progOut.valid, wr ? 8'h00 : progOut.data}, {1'b1, exp});
  endtask

  task automatic erase(input logic chip, input logic [2:0] b, input int n);
    int cnt;
    cnt = 0;
    host.prog_req(1'b0, chip, !chip, b, 22'h000000, 8'h00);
    check({31'h0, progBusy}, 32'h1);
    while (progOut.valid !== 1'b1 && cnt < 70000)
    begin
      @(posedge clk);
      #1 cnt++;
    end
    check(cnt, n);
    check({31'h0, progBusy}, 32'h0);
    if (chip)
    begin
      mem.delete();
      {rl, wl, trl, cfgw} = 16'hFFFF;
    end
    else
    begin
      for (int i = 0; i < n; i++) mem[32'h4000 * b + i] = 8'hFF;
      {rl[b], wl[b], trl[b]} = 3'h7;
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    logic [21:0] a;
    logic [7:0] d;
    void'($urandom(32'hc9e7117d));
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 6; i++) core_op(1'b0, 1'b0, 22'h300008 + i, 22'h0, 8'h00);
    erase(1'b1, 3'h0, 65536);
    core_op(1'b0, 1'b0, 22'h3FFFFE, 22'h0, 8'h00);
    core_op(1'b0, 1'b0, 22'h3FFFFF, 22'h0, 8'h00);
    core_op(1'b0, 1'b0, 22'h010000, 22'h0, 8'h00);
    for (int i = 0; i < 15; i++)
    begin
      a = (i < 7) ? edges[i] : {6'h00, 2'h3, 14'($urandom)};
      d = 8'($urandom);
      core_op(1'b1, 1'b0, a, 22'h000100, d);
      core_op(1'b0, 1'b0, a, 22'h001000, 8'h00);
    end
    core_op(1'b1, 1'b0, 22'h30000C, 22'h0, 8'hFD);
    core_op(1'b1, 1'b0, 22'h30000C, 22'h0, 8'hFF);
    core_op(1'b0, 1'b0, 22'h30000C, 22'h0, 8'h00);
    for (int i = 0; i < 7; i++) core_op(1'b0, 1'b0, edges[i], 22'h000100, 8'h00);
    core_op(1'b0, 1'b0, 22'h004000, 22'h005000, 8'h00);
    core_op(1'b1, 1'b0, 22'h30000A, 22'h0, 8'hFB);
    core_op(1'b1, 1'b0, 22'h008000, 22'h0, 8'h12);
    core_op(1'b0, 1'b1, edges[4], 22'h0, 8'h00);
    core_op(1'b0, 1'b0, 22'h008000, 22'h0, 8'h00);
    core_op(1'b0, 1'b0, edges[4], 22'h0, 8'h00);
    core_op(1'b0, 1'b1, edges[6], 22'h0, 8'h00);
    core_op(1'b0, 1'b0, edges[6], 22'h0, 8'h00);
    core_op(1'b1, 1'b0, 22'h30000B, 22'h0, 8'h9F);
    core_op(1'b0, 1'b0, 22'h30000B, 22'h0, 8'h00);
    prog_op(1'b0, 22'h000900, 8'h00);
    prog_op(1'b1, 22'h300008, 8'hFE);
    prog_op(1'b0, 22'h000900, 8'h00);
    core_op(1'b0, 1'b0, 22'h000900, 22'h000100, 8'h00);
    prog_op(1'b1, 22'h30000B, 8'hDF);
    core_op(1'b1, 1'b0, 22'h30000C, 22'h0, 8'hF0);
    core_op(1'b0, 1'b0, 22'h30000C, 22'h0, 8'h00);
    core_op(1'b0, 1'b0, 22'h30000B, 22'h0, 8'h00);
    erase(1'b0, 3'h1, 16384);
    core_op(1'b0, 1'b0, edges[3], 22'h000100, 8'h00);
    core_op(1'b0, 1'b0, 22'h30000C, 22'h0, 8'h00);
    report_and_stop();
  end
endmodule
